// [test/clock_output_sync_status_tb.sv]
// Self-checking bench of the clock output control block
`timescale 1ns/1ps
module clock_output_sync_status_tb;
    import clk_out_pkg::*;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] addr = 8'h00, wrData = 8'h00, rdData;
    logic wrStb = 1'b0, rdStb = 1'b0, syncInputPin = 1'b1, softPinMode = 1'b0;
    logic [15:0] outSrc = 16'h0000;
    logic priRefLost = 1'b0, secRefLost = 1'b0, memActive = 1'b0;
    logic [1:0] lockLost = 2'h0, rDivHalf = 2'h0, nDivHalf = 2'h0, mDivHalf = 2'h0;
    logic [1:0] calActive = 2'h0, autoSwitch = 2'h0, postDivReset;
    logic slowFall, dividerSyncRequestN, combinedVitalInterrupt, vitalPinA, vitalPinB;
    logic [7:0] outClkFall, outEnable, outMute, outTristate, outDivReset;
    logic [23:0] outFormat;
    logic [15:0] cmosPMode, cmosNMode, vv;
    int mismatches = 0, checks = 0, i, fmt, pm;
    int seed = 32'h496A;

    // Free-running 50 MHz clock
    always #10 ref_clk = ~ref_clk;

    out_clock_source src (.ref_clk, .reset, .slowFall, .outClkFall);
    clock_output_sync_status dut (.ref_clk, .reset, .addr, .wrData, .wrStb, .rdStb, .rdData, .syncInputPin,
        .softPinMode, .slowFall, .outClkFall, .outSrc, .priRefLost, .secRefLost, .lockLost, .rDivHalf,
        .nDivHalf, .mDivHalf, .calActive, .memActive, .autoSwitch, .outEnable, .outMute, .outTristate,
        .outDivReset, .postDivReset, .outFormat, .cmosPMode, .cmosNMode, .dividerSyncRequestN,
        .combinedVitalInterrupt, .vitalPinA, .vitalPinB);

    // ----------------
    // Helper tasks
    // ----------------
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        wrData <= d;
        wrStb <= 1'b1;
        @(posedge ref_clk);
        wrStb <= 1'b0;
    endtask

    task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        addr <= a;
        rdStb <= 1'b1;
        @(posedge ref_clk);
        rdStb <= 1'b0;
        #1;
        chk($sformatf("reg %0h", a), {24'h0, rdData}, {24'h0, e});
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic waitTri(input logic [7:0] e);
        for (int n = 0; n < 40 && outTristate !== e; n++) cyc(1);
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Watchdog against a hung run
    initial begin
        #(20 * 5000);
        mismatches++;
        wrap_up();
    end

    // ----------------
    // Main sequence
    // ----------------
    initial begin
        repeat (3) @(posedge ref_clk);
        reset <= 1'b0;
        rdChk(ADDR_SYNC_CTL, SYNC_CTL_RST);
        rdChk(ADDR_INT_CTL, REG_ZERO_RST);
        rdChk(8'h01, 8'h00);
        $display("test reset done");
        @(posedge ref_clk);
        outSrc <= 16'hACAA;
        for (i = 0; i < 8; i++) begin
            fmt = 1 + i % 5;
            pm = 1 + (i >> 2);
            wr(ADDR_OUT_CTL[i*8+:8], 8'((3 - pm) << 6 | fmt << 3 | pm));
        end
        cyc(4);
        for (i = 0; i < 8; i++) begin
            fmt = 1 + i % 5;
            pm = (fmt == 5) ? 1 + (i >> 2) : 0;
            chk("outFormat", outFormat[i*3+:3], fmt);
            chk("cmosPMode", cmosPMode[i*2+:2], pm);
            chk("cmosNMode", cmosNMode[i*2+:2], pm ? 3 - pm : 0);
        end
        chk("outEnable", outEnable, 8'hFF);
        wr(ADDR_OUT_CTL[23:16], 8'h80);
        cyc(4);
        chk("outEnable", outEnable, 8'hFB);
        $display("test formats done");
        wr(ADDR_MUTE_SUP_A, MUTE_SUP_OK);
        wr(ADDR_MUTE_SUP_B, MUTE_SUP_OK);
        wr(ADDR_MUTE_EN, 8'h30);
        priRefLost <= 1'b1;
        cyc(4);
        chk("outMute", outMute, 8'h10);
        @(posedge ref_clk);
        lockLost <= 2'b10;
        cyc(4);
        chk("outMute", outMute, 8'h30);
        wr(ADDR_MUTE_SUP_B, 8'hFE);
        cyc(4);
        chk("outMute", outMute, 8'h00);
        @(posedge ref_clk);
        priRefLost <= 1'b0;
        lockLost <= 2'b00;
        $display("test mute done");
        wr(ADDR_PLL1_CTL, 8'h02);
        wr(ADDR_SYNC_CTL, 8'h00);
        cyc(0);
        chk("divider_sync_request_n", dividerSyncRequestN, 1'b0);
        chk("outTristate", outTristate, 8'h00);
        waitTri(8'hCF);
        chk("outTristate", outTristate, 8'hCF);
        chk("outDivReset", outDivReset, 8'hCF);
        chk("postDivReset", postDivReset, 2'b01);
        cyc(6);
        chk("outEnable", outEnable, 8'h30);
        wr(ADDR_SYNC_CTL, SYNC_CTL_RST);
        waitTri(8'h00);
        chk("outDivReset", outDivReset, 8'h00);
        chk("postDivReset", postDivReset, 2'b00);
        cyc(4);
        chk("outEnable", outEnable, 8'hFB);
        @(posedge ref_clk);
        softPinMode <= 1'b1;
        syncInputPin <= 1'b0;
        cyc(1);
        chk("divider_sync_request_n", dividerSyncRequestN, 1'b0);
        waitTri(8'hCF);
        chk("outTristate", outTristate, 8'hCF);
        @(posedge ref_clk);
        syncInputPin <= 1'b1;
        waitTri(8'h00);
        chk("outTristate", outTristate, 8'h00);
        @(posedge ref_clk);
        softPinMode <= 1'b0;
        syncInputPin <= 1'b0;
        cyc(1);
        chk("divider_sync_request_n", dividerSyncRequestN, 1'b1);
        @(posedge ref_clk);
        syncInputPin <= 1'b1;
        $display("test sync done");
        rdChk(ADDR_RT_STAT, 8'h09);
        rdChk(ADDR_RT_STAT, 8'h00);
        rdChk(ADDR_LAT_STAT, 8'h00);
        wr(ADDR_INT_MASK, 8'h01);
        wr(ADDR_INT_CTL, 8'h01);
        priRefLost <= 1'b1;
        cyc(2);
        chk("combined_vital_interrupt", combinedVitalInterrupt, 1'b1);
        wr(ADDR_SEL_A, 8'(VITAL_COMBINED_VITAL_INTERRUPT_CODE));
        cyc(2);
        chk("vitalPinA", vitalPinA, 1'b1);
        wr(ADDR_INT_CTL, 8'h03);
        wr(ADDR_INT_MASK, 8'h03);
        cyc(1);
        chk("combined_vital_interrupt", combinedVitalInterrupt, 1'b0);
        wr(ADDR_INT_MASK, 8'h01);
        cyc(1);
        chk("combined_vital_interrupt", combinedVitalInterrupt, 1'b1);
        wr(ADDR_INT_MASK, 8'h00);
        cyc(1);
        chk("combined_vital_interrupt", combinedVitalInterrupt, 1'b0);
        @(posedge ref_clk);
        priRefLost <= 1'b0;
        cyc(2);
        rdChk(ADDR_LAT_STAT, 8'h01);
        rdChk(ADDR_LAT_STAT, 8'h00);
        wr(ADDR_INT_CTL, 8'h00);
        secRefLost <= 1'b1;
        cyc(2);
        rdChk(ADDR_LAT_STAT, 8'h00);
        rdChk(ADDR_RT_STAT, 8'h03);
        $display("test interrupt done");
        for (i = 0; i < 16; i++) begin
            @(posedge ref_clk);
            {priRefLost, secRefLost, lockLost, rDivHalf, nDivHalf, mDivHalf, calActive, memActive,
                autoSwitch} <= 15'($random(seed));
            wr(ADDR_SEL_A, 8'(i));
            wr(ADDR_SEL_B, 8'(15 - i));
            wr(ADDR_PIN_POL, 8'(i & 3));
            cyc(2);
            vv = {autoSwitch, memActive, mDivHalf, 1'b0, calActive, nDivHalf[1], rDivHalf[1], lockLost[1],
                nDivHalf[0], rDivHalf[0], lockLost[0], secRefLost, priRefLost};
            chk("vitalPinA", vitalPinA, vv[i] ^ i[0]);
            chk("vitalPinB", vitalPinB, vv[15-i] ^ i[1]);
        end
        $display("test status pins done");
        wrap_up();
    end
endmodule // clock_output_sync_status_tb

// [test/out_clock_source.sv]
// Behavioural source of output-clock falling-edge pulses
`timescale 1ns/1ps
module out_clock_source (
    input wire logic ref_clk,
    input wire logic reset,
    output logic slowFall,
    output logic [7:0] outClkFall
);
    logic [3:0] phase_r;

    // Free-running phase of the divided clocks
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            phase_r <= 4'h0;
        end else begin
            phase_r <= phase_r + 4'h1;
        end
    end

    assign slowFall = (phase_r[1:0] == 2'h3);
    // Even outputs fall on even phases, odd ones a cycle later
    assign outClkFall = phase_r[0] ? 8'hAA : 8'h55;
endmodule // out_clock_source

// [verilog/clk_out_pkg.sv]
// Register map, field layout and timing constants of the clock output control block
package clk_out_pkg;
    // Register addresses (8-bit index space)
    localparam logic [7:0] ADDR_SYNC_CTL = 8'h0C;
    localparam logic [7:0] ADDR_RT_STAT = 8'h0D;
    localparam logic [7:0] ADDR_INT_MASK = 8'h0E;
    localparam logic [7:0] ADDR_PIN_POL = 8'h0F;
    localparam logic [7:0] ADDR_LAT_STAT = 8'h10;
    localparam logic [7:0] ADDR_INT_CTL = 8'h11;
    localparam logic [7:0] ADDR_MUTE_SUP_A = 8'h14;
    localparam logic [7:0] ADDR_MUTE_SUP_B = 8'h15;
    localparam logic [7:0] ADDR_MUTE_EN = 8'h16;
    localparam logic [7:0] ADDR_SEL_A = 8'h1B;
    localparam logic [7:0] ADDR_SEL_B = 8'h1C;
    localparam logic [7:0] ADDR_PLL1_CTL = 8'h38;
    localparam logic [7:0] ADDR_PLL2_CTL = 8'h47;
    // Output control registers, output 7 in the top byte
    localparam logic [63:0] ADDR_OUT_CTL = {8'h2B, 8'h29, 8'h27, 8'h25, 8'h23, 8'h22, 8'h20, 8'h1F};
    // Field positions
    localparam int SYNC_BIT = 6;
    localparam int PLL_SYNC_EN_BIT = 1;
    localparam int INT_EN_BIT = 0;
    localparam int INT_AND_BIT = 1;
    localparam int OUT_ENA_LSB = 0;
    localparam int OUT_ENA_MSB = 5;
    localparam int FMT_LSB = 3;
    localparam int PMODE_LSB = 0;
    localparam int NMODE_LSB = 6;
    // Reset values and required mute support value
    localparam logic [7:0] SYNC_CTL_RST = 8'h40;
    localparam logic [7:0] REG_ZERO_RST = 8'h00;
    localparam logic [7:0] MUTE_SUP_OK = 8'hFF;
    // Output formats
    localparam logic [2:0] FMT_OFF = 3'h0;
    localparam logic [2:0] FMT_LVPECL = 3'h1;
    localparam logic [2:0] FMT_LVDS = 3'h2;
    localparam logic [2:0] FMT_CML = 3'h3;
    localparam logic [2:0] FMT_HCSL = 3'h4;
    localparam logic [2:0] FMT_CMOS = 3'h5;
    // Single-ended pin modes
    localparam logic [1:0] CMOS_HIZ = 2'h0;
    localparam logic [1:0] CMOS_COMP = 2'h1;
    localparam logic [1:0] CMOS_INPHASE = 2'h2;
    // Output source codes from the output mux
    localparam logic [1:0] SRC_PRI = 2'h0;
    localparam logic [1:0] SRC_SEC = 2'h1;
    localparam logic [1:0] SRC_PLL1 = 2'h2;
    localparam logic [1:0] SRC_PLL2 = 2'h3;
    // Falling edges of the slowest output clock before dividers are held
    localparam int SYNC_FALL_EDGES = 2;
    // Status pin code of the combined interrupt
    localparam int VITAL_COMBINED_VITAL_INTERRUPT_CODE = 10;
    // Sync sequencer states
    typedef enum logic [2:0] {
        SYNC_RUN = 3'b001,
        SYNC_ARM = 3'b010,
        SYNC_HELD = 3'b100
    } sync_state_e;
endpackage

// [verilog/clock_output_sync_status.sv]
// Output format, mute, sync sequencing, status pin routing and interrupt logic
//
// Overview of operation
// - Per-output format chosen by its control register
// - Mute enabled output when its source invalid
// - Single-ended pins set independently: comp, in-phase, off
// - Active-low sync from pin or register bit
// - Per-PLL enable decides which outputs obey sync
// - Sync low: tri-state drivers, hold dividers reset
// - Divider reset after slowest-clock falling edges
// - Enable changes only at output clock falling edge
// - Two selectors route vitals to status pins
// - Polarity register sets each status pin level
// - Bit selects AND or OR combining
// - Set mask bits include vitals in combined interrupt
// - Latched status set only while enabled, read-clears
// - Real-time status ignores enable, read-clears
// - Selection codes 0-15 pick listed vitals
`timescale 1ns/1ps
module clock_output_sync_status (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [7:0] addr,
    input wire logic [7:0] wrData,
    input wire logic wrStb,
    input wire logic rdStb,
    output logic [7:0] rdData,
    input wire logic syncInputPin,
    input wire logic softPinMode,
    input wire logic slowFall,
    input wire logic [7:0] outClkFall,
    input wire logic [15:0] outSrc,
    input wire logic priRefLost,
    input wire logic secRefLost,
    input wire logic [1:0] lockLost,
    input wire logic [1:0] rDivHalf,
    input wire logic [1:0] nDivHalf,
    input wire logic [1:0] mDivHalf,
    input wire logic [1:0] calActive,
    input wire logic memActive,
    input wire logic [1:0] autoSwitch,
    output logic [7:0] outEnable,
    output logic [7:0] outMute,
    output logic [7:0] outTristate,
    output logic [7:0] outDivReset,
    output logic [1:0] postDivReset,
    output logic [23:0] outFormat,
    output logic [15:0] cmosPMode,
    output logic [15:0] cmosNMode,
    output logic dividerSyncRequestN,
    output logic combinedVitalInterrupt,
    output logic vitalPinA,
    output logic vitalPinB
);
    import clk_out_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic syncBit;
        logic [1:0] syncEn;
        logic [7:0] intMask;
        logic [1:0] pinPol;
        logic intEn;
        logic andMode;
        logic [7:0] muteSupA;
        logic [7:0] muteSupB;
        logic [7:0] muteEn;
        logic [3:0] selA;
        logic [3:0] selB;
        logic [63:0] outCtl;
        logic [7:0] rtStat;
        logic [7:0] latStat;
        logic [7:0] rdData;
        logic [7:0] enLive;
        logic [7:0] muteLive;
        sync_state_e st;
        logic [1:0] fallCnt;
        logic pinA;
        logic pinB;
    } state_s;

    state_s q;
    state_s d;
    logic [7:0] srcNow;
    logic [15:0] vitalVec;
    logic [7:0] invalid;
    logic [7:0] syncAff;
    logic held;
    logic rdRt;
    logic rdLat;
    logic supOk;

    // ------------------------------------------------------------
    // Combinational decode
    // ------------------------------------------------------------
    // Interrupt sources: ref losses, lock losses, calibration, auto switch
    assign srcNow = {autoSwitch, calActive, lockLost, secRefLost, priRefLost};
    assign dividerSyncRequestN = (syncInputPin | ~softPinMode) & q.syncBit;
    assign held = (q.st == SYNC_HELD);
    assign rdRt = rdStb && (addr == ADDR_RT_STAT);
    assign rdLat = rdStb && (addr == ADDR_LAT_STAT);
    // Mute only with both support registers all-ones
    assign supOk = (q.muteSupA == MUTE_SUP_OK) && (q.muteSupB == MUTE_SUP_OK);

    always_comb begin
        if (q.intMask == 8'h00) begin
            combinedVitalInterrupt = 1'b0;
        end else if (q.andMode) begin
            combinedVitalInterrupt = &(q.latStat | ~q.intMask);
        end else begin
            combinedVitalInterrupt = |(q.latStat & q.intMask);
        end
    end

    assign vitalVec = {autoSwitch[1], autoSwitch[0], memActive, mDivHalf[1], mDivHalf[0],
                       combinedVitalInterrupt, calActive[1], calActive[0], nDivHalf[1], rDivHalf[1],
                       lockLost[1], nDivHalf[0], rDivHalf[0], lockLost[0], secRefLost, priRefLost};

    // Per-output source validity and sync membership
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            unique case (outSrc[2*i +: 2])
                SRC_PRI: invalid[i] = priRefLost;
                SRC_SEC: invalid[i] = secRefLost;
                SRC_PLL1: invalid[i] = lockLost[0];
                SRC_PLL2: invalid[i] = lockLost[1];
            endcase
            unique case (outSrc[2*i +: 2])
                SRC_PLL1: syncAff[i] = held & q.syncEn[0];
                SRC_PLL2: syncAff[i] = held & q.syncEn[1];
                default: syncAff[i] = 1'b0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        d.rdData = REG_ZERO_RST;
        // Register writes
        if (wrStb) begin
            unique case (addr)
                ADDR_SYNC_CTL: d.syncBit = wrData[SYNC_BIT];
                ADDR_INT_MASK: d.intMask = wrData;
                ADDR_PIN_POL: d.pinPol = wrData[1:0];
                ADDR_INT_CTL: begin
                    d.intEn = wrData[INT_EN_BIT];
                    d.andMode = wrData[INT_AND_BIT];
                end
                ADDR_MUTE_SUP_A: d.muteSupA = wrData;
                ADDR_MUTE_SUP_B: d.muteSupB = wrData;
                ADDR_MUTE_EN: d.muteEn = wrData;
                ADDR_SEL_A: d.selA = wrData[3:0];
                ADDR_SEL_B: d.selB = wrData[3:0];
                ADDR_PLL1_CTL: d.syncEn[0] = wrData[PLL_SYNC_EN_BIT];
                ADDR_PLL2_CTL: d.syncEn[1] = wrData[PLL_SYNC_EN_BIT];
                default: begin
                    for (int i = 0; i < 8; i++) begin
                        if (addr == ADDR_OUT_CTL[8*i +: 8]) begin
                            d.outCtl[8*i +: 8] = wrData;
                        end
                    end
                end
            endcase
        end
        // Register reads, data one cycle later
        if (rdStb) begin
            unique case (addr)
                ADDR_SYNC_CTL: d.rdData = {1'b0, q.syncBit, 6'h00};
                ADDR_RT_STAT: d.rdData = q.rtStat;
                ADDR_INT_MASK: d.rdData = q.intMask;
                ADDR_PIN_POL: d.rdData = {6'h00, q.pinPol};
                ADDR_LAT_STAT: d.rdData = q.latStat;
                ADDR_INT_CTL: d.rdData = {6'h00, q.andMode, q.intEn};
                ADDR_MUTE_SUP_A: d.rdData = q.muteSupA;
                ADDR_MUTE_SUP_B: d.rdData = q.muteSupB;
                ADDR_MUTE_EN: d.rdData = q.muteEn;
                ADDR_SEL_A: d.rdData = {4'h0, q.selA};
                ADDR_SEL_B: d.rdData = {4'h0, q.selB};
                ADDR_PLL1_CTL: d.rdData = {6'h00, q.syncEn[0], 1'b0};
                ADDR_PLL2_CTL: d.rdData = {6'h00, q.syncEn[1], 1'b0};
                default: begin
                    for (int i = 0; i < 8; i++) begin
                        if (addr == ADDR_OUT_CTL[8*i +: 8]) begin
                            d.rdData = q.outCtl[8*i +: 8];
                        end
                    end
                end
            endcase
        end
        d.rtStat = srcNow | (q.rtStat & ~{8{rdRt}});
        d.latStat = (q.latStat & ~{8{rdLat}}) | (srcNow & {8{q.intEn}});
        // Sync sequencer on slowest output clock
        // Hold after falling edges of slow clock
        // Requester keeps the request low meanwhile
        unique case (q.st)
            SYNC_RUN: begin
                d.fallCnt = 2'h0;
                if (!dividerSyncRequestN) begin
                    d.st = SYNC_ARM;
                end
            end
            SYNC_ARM: begin
                if (dividerSyncRequestN) begin
                    d.st = SYNC_RUN;
                end else if (slowFall) begin
                    d.fallCnt = q.fallCnt + 2'h1;
                    if (q.fallCnt == 2'(SYNC_FALL_EDGES - 1)) begin
                        d.st = SYNC_HELD;
                    end
                end
            end
            SYNC_HELD: begin
                if (dividerSyncRequestN && slowFall) begin
                    d.st = SYNC_RUN;
                end
            end
            default: d.st = SYNC_RUN;
        endcase
        // Enable and mute change at output falling edge
        // All-zero low bits disable the output
        // Mute enabled output on invalid source
        for (int i = 0; i < 8; i++) begin
            if (outClkFall[i]) begin
                d.enLive[i] = (q.outCtl[8*i+OUT_ENA_LSB +: 6] != 6'h00) && !syncAff[i];
                d.muteLive[i] = q.muteEn[i] && invalid[i] && supOk;
            end
        end
        d.pinA = vitalVec[q.selA] ^ q.pinPol[0];
        d.pinB = vitalVec[q.selB] ^ q.pinPol[1];
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            q <= '0;
            q.syncBit <= SYNC_CTL_RST[SYNC_BIT];
            q.st <= SYNC_RUN;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Affected drivers tri-stated, dividers held
    assign outTristate = syncAff;
    assign outDivReset = syncAff;
    assign postDivReset = {held & q.syncEn[1], held & q.syncEn[0]};
    assign outEnable = q.enLive;
    assign outMute = q.muteLive;
    assign rdData = q.rdData;
    assign vitalPinA = q.pinA;
    assign vitalPinB = q.pinB;

    // Pin modes reported only in single-ended format
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            outFormat[3*i +: 3] = q.outCtl[8*i+FMT_LSB +: 3];
            if (q.outCtl[8*i+FMT_LSB +: 3] == FMT_CMOS) begin
                cmosPMode[2*i +: 2] = q.outCtl[8*i+PMODE_LSB +: 2];
                cmosNMode[2*i +: 2] = q.outCtl[8*i+NMODE_LSB +: 2];
            end else begin
                cmosPMode[2*i +: 2] = CMOS_HIZ;
                cmosNMode[2*i +: 2] = CMOS_HIZ;
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_rtClear;
        @(posedge ref_clk) disable iff (reset) (rdRt && srcNow == 8'h00) |=> q.rtStat == 8'h00;
    endproperty
    a_rtClear: assert property (p_rtClear) else $error("real-time status not cleared by read");

    property p_latSet;
        @(posedge ref_clk) disable iff (reset) q.intEn |=> ((q.latStat & $past(srcNow)) == $past(srcNow));
    endproperty
    a_latSet: assert property (p_latSet) else $error("latched status missed an event");

    property p_latHold;
        @(posedge ref_clk) disable iff (reset) (!q.intEn && !rdLat) |=> q.latStat == $past(q.latStat);
    endproperty
    a_latHold: assert property (p_latHold) else $error("latched status changed while disabled");

    property p_armRelease;
        @(posedge ref_clk) disable iff (reset) (q.st == SYNC_ARM && dividerSyncRequestN) |=> q.st == SYNC_RUN;
    endproperty
    a_armRelease: assert property (p_armRelease) else $error("sync arm not released");

    property p_heldReset;
        @(posedge ref_clk) disable iff (reset) (q.st == SYNC_HELD) |-> postDivReset == q.syncEn;
    endproperty
    a_heldReset: assert property (p_heldReset) else $error("post divider not held in sync");

    property p_syncEntry;
        @(posedge ref_clk) disable iff (reset)
            (q.st == SYNC_ARM && !dividerSyncRequestN && slowFall && q.fallCnt == 2'(SYNC_FALL_EDGES - 1))
                |=> held;
    endproperty
    a_syncEntry: assert property (p_syncEntry) else $error("dividers not held after two edges");

    property p_pinRoute;
        @(posedge ref_clk) disable iff (reset) 1'b1 |=> vitalPinA == ($past(vitalVec[q.selA]) ^ $past(q.pinPol[0]));
    endproperty
    a_pinRoute: assert property (p_pinRoute) else $error("status pin A wrong");

    property p_enGlitchless;
        @(posedge ref_clk) disable iff (reset) !outClkFall[0] |=> outEnable[0] == $past(outEnable[0]);
    endproperty
    a_enGlitchless: assert property (p_enGlitchless) else $error("output enable moved off edge");

    property p_muteGate;
        @(posedge ref_clk) disable iff (reset) (outClkFall[4] && !supOk) |=> !outMute[4];
    endproperty
    a_muteGate: assert property (p_muteGate) else $error("mute applied without support registers");

endmodule // clock_output_sync_status
